/* File: hw/rdsp_pkg.sv */
// Constants and types for the radio data status-pin and configuration block.
// Function
// [RULE1] Threshold code picks 1, 4, 8, 12 blocks.
// [RULE2] Crystal bit: 0 low rate, 1 double.
// [RULE3] Unlocked phase follows subcarrier; reset seeds select.
// [RULE4] Locked phase: select 0 gives 90, 1 zero.
// [RULE5] Host sets select to match known subcarrier.
// [RULE6] Format bit enables offset word E.
// [RULE7] Three-bit mode routes functions onto pins.
// [RULE8] Polarity bit inverts upper aux, sync, presence.
// [RULE9] Mode 1: pins four, five show flags.
// [RULE10] Mode 4: error-count code over 48 blocks.
// [RULE11] Modes 0-2: sync pin low while synchronised.
// [RULE12] Mode 3: sync pin pulses at block start.
// [RULE13] Sync pin shows previous block's state.
// [RULE14] Host writes zeros to test bits.
// [RULE15] Mode pins select normal, standby, test.
// [RULE16] Bias bit makes soft flag easier.
// [RULE17] Strictness bit tightens presence detection.
// [RULE18] Host samples data on bit clock fall.
// [RULE19] Request pin pulled low when blocks buffered.
// [RULE20] Fields reset, update when write completes.
// [RULE21] Mode 3 error pins encode block quality.
package rdsp_pkg;
  localparam int          CLK_MHZ        = 50;
  localparam int          SYNC_PULSE_US  = 421;
  localparam int          SYNC_PULSE_CYC = SYNC_PULSE_US * CLK_MHZ;
  localparam int          ERR_WINDOW     = 48;
  localparam int          BUF_BLOCKS     = 24;
  // Word indices on the register bus.
  localparam logic [1:0]  IDX_CONFIG     = 2'h0;
  localparam logic [1:0]  IDX_STATUS     = 2'h1;
  localparam int          CFG_W          = 15;
  // Request thresholds per code {hi, lo}.
  localparam logic [4:0]  THR_CODE0      = 5'h01;
  localparam logic [4:0]  THR_CODE1      = 5'h04;
  localparam logic [4:0]  THR_CODE2      = 5'h08;
  localparam logic [4:0]  THR_CODE3      = 5'h0C;
  // Error-count bands.
  localparam logic [5:0]  ERR_BAND1      = 6'h14;
  localparam logic [5:0]  ERR_BAND2      = 6'h28;
  localparam logic [2:0]  MODE_ERRCOUNT  = 3'h4;
  localparam logic [1:0]  BASE_STATUS    = 2'h3;

  typedef struct packed {
    logic       presence_strictness;  // Bit 14.
    logic       soft_flag_bias;       // Bit 13.
    logic [3:0] test_bits;            // Bits 12:9.
    logic       pin_polarity_bit;     // Bit 8.
    logic       pin_mode_bit1;        // Bit 7.
    logic       pin_mode_bit0;        // Bit 6.
    logic       format_select;        // Bit 5.
    logic       phase_select;         // Bit 4.
    logic       phase_lock_enable;    // Bit 3.
    logic       crystal_select;       // Bit 2.
    logic       request_threshold_hi; // Bit 1.
    logic       request_threshold_lo; // Bit 0.
  } rdsp_cfg_t;

  localparam rdsp_cfg_t CFG_RESET = 15'h00D0;
endpackage : rdsp_pkg

/* File: hw/rdsp_pins.sv */
// Configuration register and open-drain status-pin logic of the radio data decoder.
`timescale 1ns/1ps
`default_nettype none
module rdsp_pins
  import rdsp_pkg::*;
#(
  parameter int PULSE_CYCLES = SYNC_PULSE_CYC
) (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic [1:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        RECOVERED_BIT_CLOCK,
  input  wire logic        RECOVERED_BIT_DATA,
  input  wire logic        SOFT_DECISION_FLAG,
  input  wire logic        SUBCARRIER_TONE,
  input  wire logic        OP_MODE_PIN_A,
  input  wire logic        OP_MODE_PIN_B,
  input  wire logic        SYNC_STATE,
  input  wire logic        SYNC_RESET,
  input  wire logic        BLOCK_START,
  input  wire logic        BLOCK_DONE,
  input  wire logic        BLOCK_UNCORRECTABLE,
  input  wire logic        BLOCK_CLEAN,
  input  wire logic        BLOCK_WRITTEN,
  input  wire logic        BLOCK_READ,
  input  wire logic        TRAFFIC_PROGRAMME_FLAG,
  input  wire logic        TRAFFIC_ANNOUNCEMENT_FLAG,
  input  wire logic        TRAFFIC_SUBCARRIER,
  input  wire logic        PROGRAM_DATA_PRESENT,
  output logic             CRYSTAL_SELECT,
  output logic             DEMOD_PHASE_ZERO,
  output logic             OFFSET_E_ENABLE,
  output logic             SOFT_FLAG_BIAS,
  output logic             PRESENCE_STRICTNESS,
  output logic             STANDBY,
  output logic             FACTORY_TEST,
  output logic [4:0]       AUX_OUT_O,
  output logic [4:0]       AUX_OUT_OE,
  output logic             SYNC_OUT_O,
  output logic             SYNC_OUT_OE,
  output logic             PROGRAM_DATA_PRESENT_OUT_O,
  output logic             PROGRAM_DATA_PRESENT_OUT_OE,
  output logic             READ_REQUEST_O,
  output logic             READ_REQUEST_OE
);
  if (PULSE_CYCLES < 8 || PULSE_CYCLES > 65535) begin : g_bad_pulse
    $error("PULSE_CYCLES must lie between 8 and 65535.");
  end

  rdsp_cfg_t   cfg_q;
  logic        wait_q;
  logic [4:0]  blk_cnt_q;
  logic [4:0]  thr_blocks;
  logic        req_cond;
  logic [ERR_WINDOW-1:0] err_hist_q;
  logic [5:0]  err_cnt_q;
  logic [1:0]  be_code;
  logic        sync_blk_q;
  logic        uncorr_q;
  logic        clean_q;
  logic [15:0] pulse_cnt_q;
  logic        pulse_q;
  logic        phase_q;
  logic [5:0]  meta_q;
  logic [5:0]  sync_q;
  logic [2:0]  mode;
  logic [1:0]  base;
  logic        pol;
  logic [6:0]  drive;
  logic [6:0]  level;
  logic        wr_acc;
  logic        rd_acc;

  assign mode   = {cfg_q.pin_polarity_bit, cfg_q.pin_mode_bit1, cfg_q.pin_mode_bit0};
  assign base   = mode[1:0];
  assign pol    = cfg_q.pin_polarity_bit;
  assign wr_acc = AVS_WRITE && !wait_q;
  assign rd_acc = AVS_READ && !wait_q;

  // Pin-side inputs pass two flops; only the second stage is read anywhere.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      meta_q <= 6'h00;
      sync_q <= 6'h00;
    end else begin
      meta_q <= {SUBCARRIER_TONE, OP_MODE_PIN_B, OP_MODE_PIN_A,
                 SOFT_DECISION_FLAG, RECOVERED_BIT_DATA, RECOVERED_BIT_CLOCK};
      sync_q <= meta_q;
    end
  end

  // One wait cycle per access keeps read data registered; unmapped reads return zero.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      wait_q       <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end else if ((AVS_READ || AVS_WRITE) && wait_q) begin
      wait_q <= 1'b0;
      case (AVS_ADDRESS)
        IDX_CONFIG: AVS_READDATA <= {17'h00000, cfg_q};
        IDX_STATUS: AVS_READDATA <= {15'h0000, sync_q[4:3], phase_q, err_cnt_q, blk_cnt_q, uncorr_q, clean_q, sync_blk_q};
        default:    AVS_READDATA <= 32'h0000_0000;
      endcase
    end else begin
      wait_q <= 1'b1;
    end
  end
  assign AVS_WAITREQUEST = wait_q;

  // Fields load their reset values and change only when a write is accepted.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cfg_q <= CFG_RESET; // RULE20
    end else if (wr_acc && AVS_ADDRESS == IDX_CONFIG) begin
      cfg_q <= AVS_WRITEDATA[CFG_W-1:0]; // RULE20 RULE14
    end
  end

  // Static configuration reaches the decoder core through flops.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      CRYSTAL_SELECT      <= 1'b0;
      OFFSET_E_ENABLE     <= 1'b0;
      SOFT_FLAG_BIAS      <= 1'b0;
      PRESENCE_STRICTNESS <= 1'b0;
      STANDBY             <= 1'b0;
      FACTORY_TEST        <= 1'b0;
    end else begin
      CRYSTAL_SELECT      <= cfg_q.crystal_select; // RULE2
      OFFSET_E_ENABLE     <= cfg_q.format_select; // RULE6
      SOFT_FLAG_BIAS      <= cfg_q.soft_flag_bias; // RULE16
      PRESENCE_STRICTNESS <= cfg_q.presence_strictness; // RULE17
      STANDBY             <= !sync_q[3] && sync_q[4]; // RULE15
      FACTORY_TEST        <= sync_q[3]; // RULE15
    end
  end

  // Locked phase follows the select bit; otherwise the subcarrier decides after a seeded start.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      phase_q <= 1'b1;
    end else if (cfg_q.phase_lock_enable) begin
      phase_q <= cfg_q.phase_select; // RULE4
    end else if (SYNC_RESET) begin
      phase_q <= cfg_q.phase_select; // RULE3
    end else begin
      phase_q <= TRAFFIC_SUBCARRIER; // RULE3
    end
  end
  assign DEMOD_PHASE_ZERO = phase_q;

  // Buffered block count; a write and a read in one cycle cancel so none is lost.
  always_ff @(posedge CLK) begin
    if (SRST || SYNC_RESET) begin
      blk_cnt_q <= 5'h00;
    end else if (BLOCK_WRITTEN && !BLOCK_READ && blk_cnt_q != 5'(BUF_BLOCKS)) begin
      blk_cnt_q <= blk_cnt_q + 5'h01;
    end else if (BLOCK_READ && !BLOCK_WRITTEN && blk_cnt_q != 5'h00) begin
      blk_cnt_q <= blk_cnt_q - 5'h01;
    end
  end

  // Threshold decode, code bits taken as {hi, lo}.
  always_comb begin
    case ({cfg_q.request_threshold_hi, cfg_q.request_threshold_lo})
      2'h0:    thr_blocks = THR_CODE0; // RULE1
      2'h1:    thr_blocks = THR_CODE1;
      2'h2:    thr_blocks = THR_CODE2;
      default: thr_blocks = THR_CODE3;
    endcase
  end
  assign req_cond = blk_cnt_q >= thr_blocks;

  // Pulling the request pin low means enabling its driver.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      READ_REQUEST_OE <= 1'b0;
      READ_REQUEST_O  <= 1'b0;
    end else begin
      READ_REQUEST_OE <= req_cond; // RULE19 RULE1
      READ_REQUEST_O  <= 1'b0;
    end
  end

  // Sliding error window: add the newest block, drop the one 48 blocks back.
  always_ff @(posedge CLK) begin
    if (SRST || SYNC_RESET) begin
      err_hist_q <= '0;
      err_cnt_q  <= 6'h00;
    end else if (BLOCK_DONE) begin
      err_hist_q <= {err_hist_q[ERR_WINDOW-2:0], !BLOCK_CLEAN};
      err_cnt_q  <= err_cnt_q + {5'h00, !BLOCK_CLEAN} - {5'h00, err_hist_q[ERR_WINDOW-1]}; // RULE10
    end
  end
  assign be_code = (err_cnt_q == 6'h00) ? 2'h0 : (err_cnt_q <= ERR_BAND1) ? 2'h1 :
                   (err_cnt_q <= ERR_BAND2) ? 2'h2 : 2'h3; // RULE10

  // Block quality and the sync state that applied to the block just ended.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      uncorr_q   <= 1'b0;
      clean_q    <= 1'b1;
      sync_blk_q <= 1'b0;
    end else begin
      if (BLOCK_DONE) begin
        uncorr_q <= BLOCK_UNCORRECTABLE; // RULE21
        clean_q  <= BLOCK_CLEAN && !BLOCK_UNCORRECTABLE;
      end
      if (BLOCK_START) begin
        sync_blk_q <= SYNC_STATE; // RULE13
      end
    end
  end

  // Block-start pulse timer; a new start simply reloads it.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pulse_cnt_q <= 16'h0000;
      pulse_q     <= 1'b0;
    end else if (BLOCK_START) begin
      pulse_cnt_q <= 16'(PULSE_CYCLES - 1); // RULE12
      pulse_q     <= 1'b1;
    end else if (pulse_cnt_q != 16'h0000) begin
      pulse_cnt_q <= pulse_cnt_q - 16'h0001;
    end else begin
      pulse_q <= 1'b0;
    end
  end

  // Route functions to pins as levels; drive marks pins that are not left open.
  always_comb begin
    drive = 7'h00;
    level = 7'h7F;
    if (mode == MODE_ERRCOUNT) begin
      drive[4:3] = 2'h3;
      level[3]   = be_code[1]; // RULE10
      level[4]   = be_code[0];
    end else begin
      case (base)
        2'h1: begin
          drive[4:3] = 2'h3;
          level[3]   = pol ^ !TRAFFIC_PROGRAMME_FLAG; // RULE9 RULE8
          level[4]   = pol ^ !TRAFFIC_ANNOUNCEMENT_FLAG;
        end
        2'h2: begin
          drive[4:0] = 5'h1F;
          level[2:0] = sync_q[2:0];
          level[3]   = pol ^ !sync_q[5]; // RULE8
          level[4]   = pol ^ !TRAFFIC_SUBCARRIER;
        end
        2'h3: begin
          drive[4:0] = 5'h1F;
          level[2:0] = sync_q[2:0]; // RULE18
          level[3]   = pol ^ !uncorr_q; // RULE21 RULE8
          level[4]   = pol ^ clean_q; // RULE21
        end
        default: begin
          drive[4:0] = 5'h00;
        end
      endcase
    end
    drive[5] = 1'b1;
    if (base == BASE_STATUS && mode != MODE_ERRCOUNT) begin
      level[5] = pol ^ (sync_blk_q ? pulse_q : 1'b1); // RULE12 RULE13
    end else begin
      level[5] = pol ^ !sync_blk_q; // RULE11 RULE13
    end
    drive[6] = 1'b1;
    level[6] = pol ^ !PROGRAM_DATA_PRESENT; // RULE8
  end

  // Open-drain pins: a driven low level enables the driver, everything else releases.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      AUX_OUT_OE                  <= 5'h00;
      AUX_OUT_O                   <= 5'h00;
      SYNC_OUT_OE                 <= 1'b0;
      SYNC_OUT_O                  <= 1'b0;
      PROGRAM_DATA_PRESENT_OUT_OE <= 1'b0;
      PROGRAM_DATA_PRESENT_OUT_O  <= 1'b0;
    end else begin
      AUX_OUT_OE                  <= drive[4:0] & ~level[4:0]; // RULE7
      AUX_OUT_O                   <= 5'h00;
      SYNC_OUT_OE                 <= drive[5] & ~level[5];
      SYNC_OUT_O                  <= 1'b0;
      PROGRAM_DATA_PRESENT_OUT_OE <= drive[6] & ~level[6];
      PROGRAM_DATA_PRESENT_OUT_O  <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  chk_cfg_reset_value: assert property ($fell(SRST) |-> cfg_q == CFG_RESET) // RULE20
    else $error("Configuration not at reset value after reset.");
  chk_cfg_write_lands: assert property (wr_acc && AVS_ADDRESS == IDX_CONFIG |=> // RULE20
    cfg_q == $past(AVS_WRITEDATA[CFG_W-1:0]))
    else $error("Accepted write did not update configuration.");
  chk_request_level: assert property (1'b1 |=> READ_REQUEST_OE == $past(req_cond)) // RULE1 RULE19
    else $error("Request pin disagrees with block count threshold.");
  chk_phase_locked: assert property (cfg_q.phase_lock_enable |=> // RULE4
    DEMOD_PHASE_ZERO == $past(cfg_q.phase_select))
    else $error("Locked phase does not follow select bit.");
  chk_phase_seed: assert property (!cfg_q.phase_lock_enable && SYNC_RESET |=> // RULE3
    DEMOD_PHASE_ZERO == $past(cfg_q.phase_select))
    else $error("Phase not seeded by select bit after sync reset.");
  chk_offset_e_en: assert property (1'b1 |=> OFFSET_E_ENABLE == $past(cfg_q.format_select)) // RULE6
    else $error("Offset word E enable does not follow format bit.");
  chk_mode1_traffic: assert property (mode == 3'h1 |=> AUX_OUT_OE[3] == $past(TRAFFIC_PROGRAMME_FLAG) // RULE9
    && AUX_OUT_OE[4] == $past(TRAFFIC_ANNOUNCEMENT_FLAG))
    else $error("Mode 1 traffic pins wrong.");
  chk_errcount_code: assert property (mode == MODE_ERRCOUNT |=> AUX_OUT_OE[3] == !$past(be_code[1]) // RULE10
    && AUX_OUT_OE[4] == !$past(be_code[0]))
    else $error("Error-count pins wrong.");
  chk_sync_level: assert property (base != BASE_STATUS && !pol |=> SYNC_OUT_OE == $past(sync_blk_q)) // RULE11 RULE13
    else $error("Sync pin level wrong in modes 0 to 2.");
  chk_sync_pulse_len: assert property ($rose(pulse_q) |-> pulse_q [*8]) // RULE12
    else $error("Sync pulse too short.");
  chk_open_mode0: assert property (mode == 3'h0 |=> AUX_OUT_OE == 5'h00) // RULE7
    else $error("Auxiliary pins driven in mode 0.");
  chk_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("Bus answer late.");

  cov_mode3_pulse: cover property (mode == 3'h3 && sync_blk_q && $rose(pulse_q));
  cov_request_set: cover property ($rose(READ_REQUEST_OE));
  cov_errcount_top: cover property (mode == MODE_ERRCOUNT && be_code == 2'h3);
  cov_locked_phase: cover property (cfg_q.phase_lock_enable && !DEMOD_PHASE_ZERO);
endmodule : rdsp_pins
`default_nettype wire

/* File: tb/rdsp_host_model.sv */
// Host-side model: pull-ups on the open-drain status pins and a bit-stream receiver.
`timescale 1ns/1ps
`default_nettype none
module rdsp_host_model (
  input  wire logic [4:0] aux_oe,
  input  wire logic       sync_oe,
  input  wire logic       pdp_oe,
  input  wire logic       req_oe,
  output logic      [4:0] aux_pin,
  output logic            sync_pin,
  output logic            pdp_pin,
  output logic            req_pin,
  output logic            rx_bit
);
  // Pull-ups hold every released line high; the device can only sink it.
  assign aux_pin  = ~aux_oe;
  assign sync_pin = ~sync_oe;
  assign pdp_pin  = ~pdp_oe;
  assign req_pin  = ~req_oe;
  // Data is taken on the falling bit clock, half a bit away from its changes.
  always @(negedge aux_pin[0]) rx_bit <= aux_pin[1];
endmodule : rdsp_host_model
`default_nettype wire

/* File: tb/rdsp_pins_tb.sv */
// Self-checking bench for the radio data status-pin and configuration block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module rdsp_pins_tb;
  import rdsp_pkg::*;
  localparam int PW = 16;
  logic        CLK = 0, SRST = 1, AVS_READ = 0, AVS_WRITE = 0, AVS_WAITREQUEST;
  logic [1:0]  AVS_ADDRESS = '0;
  logic [31:0] AVS_WRITEDATA = '0, AVS_READDATA, rd;
  logic        bclk = 0, bdat = 0, op_a = 0, op_b = 0, sync_st = 0, uncorr = 0, clean = 0;
  logic        tp = 0, ta = 0, sub = 0, pdp = 0, lk_en = 0, tone = 0;
  logic [4:0]  ev = '0; // Pulses {read, written, sync reset, done, start}.
  logic        crys, phz, offe, bias, strict, stby, ftest, sync_o, sync_oe, pdp_o, pdp_oe, rr_o, rr_oe;
  logic        sync_pin, pdp_pin, rr_pin, rx_bit;
  logic [4:0]  aux_o, aux_oe, aux_pin;
  int          error_cnt = 0, n_compared = 0, thr;

  rdsp_pins #(.PULSE_CYCLES(PW)) DUT (.CLK(CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .RECOVERED_BIT_CLOCK(bclk), .RECOVERED_BIT_DATA(bdat),
    .SOFT_DECISION_FLAG(1'b0), .SUBCARRIER_TONE(tone), .OP_MODE_PIN_A(op_a), .OP_MODE_PIN_B(op_b),
    .SYNC_STATE(sync_st), .SYNC_RESET(ev[2]), .BLOCK_START(ev[0]), .BLOCK_DONE(ev[1]),
    .BLOCK_UNCORRECTABLE(uncorr), .BLOCK_CLEAN(clean), .BLOCK_WRITTEN(ev[3]), .BLOCK_READ(ev[4]),
    .TRAFFIC_PROGRAMME_FLAG(tp), .TRAFFIC_ANNOUNCEMENT_FLAG(ta), .TRAFFIC_SUBCARRIER(sub),
    .PROGRAM_DATA_PRESENT(pdp), .CRYSTAL_SELECT(crys), .DEMOD_PHASE_ZERO(phz), .OFFSET_E_ENABLE(offe),
    .SOFT_FLAG_BIAS(bias), .PRESENCE_STRICTNESS(strict), .STANDBY(stby), .FACTORY_TEST(ftest),
    .AUX_OUT_O(aux_o), .AUX_OUT_OE(aux_oe), .SYNC_OUT_O(sync_o), .SYNC_OUT_OE(sync_oe),
    .PROGRAM_DATA_PRESENT_OUT_O(pdp_o), .PROGRAM_DATA_PRESENT_OUT_OE(pdp_oe),
    .READ_REQUEST_O(rr_o), .READ_REQUEST_OE(rr_oe));
  rdsp_host_model host (.aux_oe(aux_oe), .sync_oe(sync_oe), .pdp_oe(pdp_oe), .req_oe(rr_oe),
    .aux_pin(aux_pin), .sync_pin(sync_pin), .pdp_pin(pdp_pin), .req_pin(rr_pin), .rx_bit(rx_bit));

  // System clock and the 160 ns bit clock, which stands still outside streams.
  initial forever #10 CLK = ~CLK;
  always begin
    repeat (4) @(posedge CLK);
    if (lk_en) bclk <= ~bclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc
  // One bus access; the request stands until waitrequest is seen low, and only the watchdog ends a hang.
  task automatic avs(input logic w, input logic [1:0] a, input logic [31:0] d);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= ~w;
    do begin
      @(posedge CLK);
    end while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : avs
  // Config word with the test bits always zero.
  function automatic logic [31:0] cw(input logic [2:0] m, input logic [14:0] x);
    return {17'h0, (x & 15'h61FF) | {6'h0, m, 6'h0}};
  endfunction : cw
  task automatic fire(input logic [4:0] m);
    @(posedge CLK);
    ev <= m;
    @(posedge CLK);
    ev <= 5'h00;
  endtask : fire
  task automatic ph(input logic [14:0] x, input logic s, input logic e);
    avs(1'b1, IDX_CONFIG, cw(3'h3, x));
    sub <= s;
    cyc(3);
    `CHK("phase", e, phz)
  endtask : ph
  task automatic pins2(input logic [2:0] m, input logic p, input logic a, input logic [1:0] e);
    avs(1'b1, IDX_CONFIG, cw(m, 15'h0010));
    tp <= p;
    ta <= a;
    cyc(3);
    `CHK("aux 4/5 pins", e, aux_pin[4:3])
  endtask : pins2
  task automatic bq(input logic u, input logic c, input logic [1:0] e);
    uncorr <= u;
    clean <= c;
    fire(5'h02);
    cyc(2);
    `CHK("quality pins", e, aux_pin[4:3])
  endtask : bq
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // A hang is cut short long after the sequence should have ended.
  initial begin
    cyc(30000);
    error_cnt++;
    final_report();
  end

  initial begin
    cyc(10);
    SRST <= 1'b0;
    cyc(2);
    avs(1'b0, IDX_CONFIG, 32'h0);
    `CHK("cfg reset", 32'h000000D0, rd)
    `CHK("fields reset", 4'h0, {crys, offe, bias, strict})
    avs(1'b1, IDX_CONFIG, cw(3'h3, 15'h6034));
    avs(1'b1, IDX_STATUS, 32'h0);
    avs(1'b1, 2'h2, 32'h7FFF);
    avs(1'b0, IDX_CONFIG, 32'h0);
    `CHK("cfg readback", 32'h000060F4, rd)
    avs(1'b0, 2'h3, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    cyc(2);
    `CHK("crystal", 1'b1, crys)
    `CHK("offset E", 1'b1, offe)
    `CHK("soft bias", 1'b1, bias)
    `CHK("strictness", 1'b1, strict)
    ph(15'h0008, 1'b0, 1'b0);
    ph(15'h0018, 1'b1, 1'b1);
    ph(15'h0010, 1'b1, 1'b1);
    ph(15'h0010, 1'b0, 1'b0);
    // Each threshold code, counted up from an emptied buffer.
    sync_st <= 1'b1;
    for (int v = 0; v < 4; v++) begin
      thr = (v == 0) ? 1 : 4 * v;
      avs(1'b1, IDX_CONFIG, cw(3'h3, 15'h0010 | 15'(v)));
      fire(5'h04);
      for (int k = 1; k <= thr; k++) begin
        fire(5'h08);
        cyc(2);
        `CHK("request pin", (k < thr) ? 1'b1 : 1'b0, rr_pin)
      end
      fire(5'h10);
      cyc(2);
      `CHK("request released", 1'b1, rr_pin)
    end
    pins2(3'h1, 1'b1, 1'b0, 2'b10);
    pins2(3'h1, 1'b0, 1'b1, 2'b01);
    pins2(3'h5, 1'b1, 1'b0, 2'b01);
    // Level sync form, lagging by one block.
    avs(1'b1, IDX_CONFIG, cw(3'h0, 15'h0010));
    pdp <= 1'b1;
    fire(5'h01);
    cyc(3);
    `CHK("sync level", 1'b0, sync_pin)
    `CHK("presence pin", 1'b0, pdp_pin)
    sync_st <= 1'b0;
    cyc(3);
    `CHK("sync previous", 1'b0, sync_pin)
    fire(5'h01);
    cyc(3);
    `CHK("sync lost", 1'b1, sync_pin)
    avs(1'b1, IDX_CONFIG, cw(3'h5, 15'h0010));
    cyc(3);
    `CHK("sync inverted", 2'b01, {sync_pin, pdp_pin})
    // Block-start pulse form.
    avs(1'b1, IDX_CONFIG, cw(3'h3, 15'h0010));
    sync_st <= 1'b1;
    fire(5'h01);
    cyc(4);
    `CHK("sync pulse", 1'b1, sync_pin)
    cyc(PW + 4);
    `CHK("sync after pulse", 1'b0, sync_pin)
    sync_st <= 1'b0;
    fire(5'h01);
    cyc(PW + 6);
    `CHK("sync unsync", 1'b1, sync_pin)
    bq(1'b1, 1'b0, 2'b00);
    bq(1'b0, 1'b0, 2'b01);
    bq(1'b0, 1'b1, 2'b11);
    bdat <= 1'b1;
    lk_en <= 1'b1;
    cyc(40);
    `CHK("stream bit", 1'b1, rx_bit)
    bdat <= 1'b0;
    cyc(40);
    `CHK("stream bit", 1'b0, rx_bit)
    lk_en <= 1'b0;
    // Tone and subcarrier set on the upper pins, in both polarities; the tone input is asynchronous.
    tone <= 1'b1;
    avs(1'b1, IDX_CONFIG, cw(3'h2, 15'h0010));
    cyc(6);
    `CHK("mode 2 pins", 3'b100, aux_pin[4:2])
    avs(1'b1, IDX_CONFIG, cw(3'h6, 15'h0010));
    cyc(3);
    `CHK("mode 6 pins", 3'b010, aux_pin[4:2])
    // Error bands over a fresh window; pins read {aux5, aux4} = {low, high}.
    avs(1'b1, IDX_CONFIG, cw(3'h4, 15'h0010));
    fire(5'h04);
    uncorr <= 1'b1;
    clean <= 1'b0;
    for (int i = 0; i <= 48; i++) begin
      if (i > 0) fire(5'h02);
      if (i inside {0, 1, 20, 21, 40, 41, 48}) begin
        cyc(2);
        `CHK("error bands", (i == 0) ? 2'b00 : (i <= 20) ? 2'b10 : (i <= 40) ? 2'b01 : 2'b11, aux_pin[4:3])
      end
    end
    op_b <= 1'b1;
    cyc(6);
    `CHK("standby", 2'b10, {stby, ftest})
    op_a <= 1'b1;
    cyc(6);
    `CHK("factory test", 2'b01, {stby, ftest})
    avs(1'b0, IDX_STATUS, 32'h0);
    `CHK("status word", 32'h0001B004, rd)
    `CHK("pin drive values", 8'h00, {aux_o, sync_o, pdp_o, rr_o})
    final_report();
  end
endmodule : rdsp_pins_tb
`default_nettype wire
